// file: logic/irq_prio_ctrl.sv
// priority arbitration and masking of a nested interrupt controller
// Operation
// - a source whose level is equal to or above the mask number is held back, and a mask of zero turns masking off.
// - with masking on, only a level numerically below the mask passes, and lower numbers are more urgent.
// - only the top three priority bits take part in level comparisons; the mask-off check compares all eight mask bits.
// - among requests present together the most urgent wins, level zero being the most urgent.
// - a software trigger pends the source just as its line would, still needing enable and priority.
// - only enabled sources are ever offered to the core.
// - the global disable gates only the request to the core and leaves the enables alone.
// - clearing pending drops any unserviced request of that source.
// - a set pending runs at the next chance priorities allow, after a more urgent running handler.
`timescale 1ns/1ps
`default_nettype none
module irq_prio_ctrl (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic ce,
    // register port
    input wire logic [irq_prio_pkg::ADDR_W-1:0] regAddr,
    input wire logic [irq_prio_pkg::DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [irq_prio_pkg::DATA_W-1:0] regRdata,
    // peripheral lines
    input wire logic [irq_prio_pkg::NUM_SRC-1:0] irqLine,
    // core side
    output logic irqReq,
    output logic [irq_prio_pkg::SRC_W-1:0] irqVector,
    input wire logic irqAck,
    input wire logic irqDone,
    input wire logic [irq_prio_pkg::SRC_W-1:0] irqDoneSrc
);
    localparam int N = irq_prio_pkg::NUM_SRC;
    localparam int LW = irq_prio_pkg::LVL_W;

    function automatic logic [LW-1:0] lvlOf(input logic [7:0] p);
        lvlOf = p[irq_prio_pkg::LVL_HI:irq_prio_pkg::LVL_LO];
    endfunction

    function automatic logic isPrioAddr(input logic [7:0] a);
        isPrioAddr = a >= irq_prio_pkg::OFS_PRIO_BASE &&
            a <= irq_prio_pkg::OFS_PRIO_LAST && a[1:0] == 2'h0;
    endfunction

    logic [N-1:0] enQ;
    logic [N-1:0] pendQ;
    logic [N-1:0] activeQ;
    logic [7:0] prioQ [N];
    logic [7:0] maskQ;
    logic masterEnQ;
    logic reqQ;
    logic [irq_prio_pkg::SRC_W-1:0] vecQ;
    logic [LW-1:0] reqLvlQ;
    logic [irq_prio_pkg::DATA_W-1:0] rdataQ;
    logic [N-1:0] eligible;
    logic [N*LW-1:0] lvls;
    logic [N-1:0] setVec;
    logic [N-1:0] clrVec;
    logic [N-1:0] trigVec;
    logic [N-1:0] takeVec;
    logic ackTake;
    logic pickFound;
    logic [irq_prio_pkg::SRC_W-1:0] pickIdx;
    logic [LW-1:0] pickLvl;
    logic runFound;
    logic [LW-1:0] runLvl;
    logic [irq_prio_pkg::SRC_W-1:0] prioIdx;
    logic wrEn;
    logic wrSet;
    logic wrClr;
    logic wrTrig;

    assign wrEn = regWr && regAddr == irq_prio_pkg::OFS_ENABLE;
    assign wrSet = regWr && regAddr == irq_prio_pkg::OFS_PENDSET;
    assign wrClr = regWr && regAddr == irq_prio_pkg::OFS_PENDCLR;
    assign wrTrig = regWr && regAddr == irq_prio_pkg::OFS_TRIGGER;
    assign prioIdx = regAddr[4:2];
    assign ackTake = irqAck && reqQ;
    assign trigVec = wrTrig ? N'(1) << regWdata[irq_prio_pkg::SRC_W-1:0]
                            : '0;
    assign takeVec = ackTake ? N'(1) << vecQ : '0;
    // hardware and software sets win over a clear in the same cycle
    assign setVec = irqLine | trigVec |
        (wrSet ? regWdata[N-1:0] : '0);
    assign clrVec = (wrClr ? regWdata[N-1:0] : '0) | takeVec;

    for (genvar g = 0; g < N; g++) begin : gSrc
        assign lvls[g*LW +: LW] = lvlOf(prioQ[g]);
        // masking, enable and preemption threshold per source
        assign eligible[g] = pendQ[g] && enQ[g] && !activeQ[g] &&
            (maskQ == irq_prio_pkg::MASK_OFF ||
             lvlOf(prioQ[g]) < lvlOf(maskQ)) &&
            (!runFound || lvlOf(prioQ[g]) < runLvl);

        always_ff @(posedge core_clk or negedge nrst) begin
            if (!nrst) begin
                prioQ[g] <= irq_prio_pkg::RST_PRIO;
            end else if (ce && regWr && isPrioAddr(regAddr) &&
                         prioIdx == irq_prio_pkg::SRC_W'(g)) begin
                prioQ[g] <= regWdata[7:0];
            end
        end
    end

    prio_arbiter uPick (
        .core_clk(core_clk),
        .nrst(nrst),
        .cand(eligible),
        .lvls(lvls),
        .found(pickFound),
        .idx(pickIdx),
        .level(pickLvl)
    );

    // the most urgent running handler sets the preemption bar
    prio_arbiter uRun (
        .core_clk(core_clk),
        .nrst(nrst),
        .cand(activeQ),
        .lvls(lvls),
        .found(runFound),
        .idx(),
        .level(runLvl)
    );

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            enQ <= irq_prio_pkg::RST_ENABLE;
        end else if (ce && wrEn) begin
            enQ <= regWdata[N-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pendQ <= '0;
        end else if (ce) begin
            pendQ <= (pendQ & ~clrVec) | setVec;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            activeQ <= '0;
        end else if (ce) begin
            activeQ <= (activeQ & ~(irqDone ? N'(1) << irqDoneSrc : '0))
                | takeVec;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            maskQ <= irq_prio_pkg::RST_MASK;
            masterEnQ <= irq_prio_pkg::RST_MASTER;
        end else if (ce && regWr) begin
            if (regAddr == irq_prio_pkg::OFS_MASK) begin
                maskQ <= regWdata[7:0];
            end
            if (regAddr == irq_prio_pkg::OFS_MASTER) begin
                masterEnQ <= regWdata[0];
            end
        end
    end

    // request drops for one cycle after a take so the same pick is not
    // offered twice before pending and active settle
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reqQ <= 1'b0;
            vecQ <= '0;
            reqLvlQ <= irq_prio_pkg::LVL_NONE;
        end else if (ce) begin
            reqQ <= pickFound && masterEnQ && !ackTake;
            vecQ <= pickIdx;
            reqLvlQ <= pickLvl;
        end
    end

    assign irqReq = reqQ;
    assign irqVector = vecQ;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rdataQ <= '0;
        end else if (ce && regRd) begin
            rdataQ <= '0;
            unique case (regAddr)
                irq_prio_pkg::OFS_ENABLE: rdataQ[N-1:0] <= enQ;
                irq_prio_pkg::OFS_PENDSET: rdataQ[N-1:0] <= pendQ;
                irq_prio_pkg::OFS_PENDCLR: rdataQ[N-1:0] <= pendQ;
                irq_prio_pkg::OFS_MASK: rdataQ[7:0] <= maskQ;
                irq_prio_pkg::OFS_MASTER: rdataQ[0] <= masterEnQ;
                irq_prio_pkg::OFS_STATUS: rdataQ <= {8'h00, activeQ,
                    4'h0, reqQ, vecQ, 5'h00, reqLvlQ};
                default: begin
                    if (isPrioAddr(regAddr)) begin
                        rdataQ[7:0] <= prioQ[prioIdx];
                    end
                end
            endcase
        end
    end
    assign regRdata = rdataQ;

    // checker helpers
    logic [N-1:0] eligPastQ;
    logic [LW-1:0] runPastQ;
    logic runPastFoundQ;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            eligPastQ <= '0;
            runPastQ <= irq_prio_pkg::LVL_NONE;
            runPastFoundQ <= 1'b0;
        end else if (ce) begin
            eligPastQ <= eligible;
            runPastQ <= runLvl;
            runPastFoundQ <= runFound;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst || !ce);

    sequence setWrite_s;
        wrSet && ce;
    endsequence
    sequence pendHeld_s;
        (pendQ & $past(regWdata[N-1:0])) == $past(regWdata[N-1:0]);
    endsequence

    maskBlocks_a: assert property (
        reqQ && $past(maskQ) != irq_prio_pkg::MASK_OFF && ce
        |-> reqLvlQ < lvlOf($past(maskQ)))
        else $error("request passed at or above the mask level");
    maskStrict_a: assert property (
        ce && maskQ != irq_prio_pkg::MASK_OFF && masterEnQ && !ackTake
        && pickFound |=> reqQ && reqLvlQ < lvlOf($past(maskQ)))
        else $error("unmasked pick not offered below the mask");
    onlyEnabled_a: assert property (
        reqQ |-> eligPastQ[vecQ])
        else $error("request offered for an ineligible source");
    masterGate_a: assert property (
        !masterEnQ && ce |=> !reqQ)
        else $error("request left the controller while disabled");
    masterKeepsEn_a: assert property (
        regWr && regAddr == irq_prio_pkg::OFS_MASTER && ce |=> $stable(enQ))
        else $error("global disable touched the enables");
    pendClear_a: assert property (
        wrClr && ce |=> (pendQ & $past(regWdata[N-1:0]) & ~$past(setVec))
        == '0)
        else $error("cleared pending survived");
    trigPends_a: assert property (
        wrTrig && ce |=> (pendQ & $past(trigVec)) != '0)
        else $error("software trigger did not pend");
    pendSet_a: assert property (
        setWrite_s |=> pendHeld_s)
        else $error("pend set lost");
    nestBar_a: assert property (
        reqQ && runPastFoundQ |-> reqLvlQ < runPastQ)
        else $error("request did not beat the running handler");
    takeActive_a: assert property (
        ackTake && ce |=> (activeQ & $past(takeVec)) != '0 && !reqQ)
        else $error("taken source not marked running");
endmodule
`default_nettype wire

// file: logic/irq_prio_pkg.sv
// constants shared by the priority interrupt controller
package irq_prio_pkg;
    localparam int NUM_SRC = 8;
    localparam int SRC_W = 3;
    localparam int PRIO_W = 8;
    localparam int LVL_W = 3;
    localparam int LVL_HI = 7;
    localparam int LVL_LO = 5;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // register byte offsets
    localparam logic [7:0] OFS_ENABLE = 8'h00;
    localparam logic [7:0] OFS_PENDSET = 8'h04;
    localparam logic [7:0] OFS_PENDCLR = 8'h08;
    localparam logic [7:0] OFS_TRIGGER = 8'h0C;
    localparam logic [7:0] OFS_MASK = 8'h10;
    localparam logic [7:0] OFS_MASTER = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_PRIO_BASE = 8'h20;
    localparam logic [7:0] OFS_PRIO_LAST = 8'h3C;
    // reset values and the mask-off code
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_PRIO = 8'h00;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic RST_MASTER = 1'b0;
    localparam logic [7:0] MASK_OFF = 8'h00;
    localparam logic [2:0] LVL_NONE = 3'h7;
endpackage

// file: logic/prio_arbiter.sv
// picks the most urgent flagged source by 3-bit level
`timescale 1ns/1ps
`default_nettype none
module prio_arbiter (
    // clock for checks only
    input wire logic core_clk,
    input wire logic nrst,
    // candidates
    input wire logic [irq_prio_pkg::NUM_SRC-1:0] cand,
    input wire logic [irq_prio_pkg::NUM_SRC*irq_prio_pkg::LVL_W-1:0] lvls,
    // winner
    output logic found,
    output logic [irq_prio_pkg::SRC_W-1:0] idx,
    output logic [irq_prio_pkg::LVL_W-1:0] level
);
    // strict compare keeps the lowest index on a tie
    always_comb begin
        found = 1'b0;
        idx = '0;
        level = irq_prio_pkg::LVL_NONE;
        for (int i = 0; i < irq_prio_pkg::NUM_SRC; i++) begin
            if (cand[i] && (!found ||
                lvls[i*irq_prio_pkg::LVL_W +: irq_prio_pkg::LVL_W] < level))
            begin
                found = 1'b1;
                idx = irq_prio_pkg::SRC_W'(i);
                level = lvls[i*irq_prio_pkg::LVL_W +: irq_prio_pkg::LVL_W];
            end
        end
    end

    for (genvar g = 0; g < irq_prio_pkg::NUM_SRC; g++) begin : gChk
        noneMoreUrgent_a: assert property (@(posedge core_clk)
            disable iff (!nrst)
            found |-> !(cand[g] &&
                lvls[g*irq_prio_pkg::LVL_W +: irq_prio_pkg::LVL_W] < level))
            else $error("a more urgent candidate was passed over");
    end
endmodule
`default_nettype wire

// file: dv/core_model.sv
// behavioural processor core taking and finishing requests
`timescale 1ns/1ps
`default_nettype none
module core_model #(
    parameter int HOLD = 6
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // request from controller
    input wire logic irqReq,
    input wire logic [irq_prio_pkg::SRC_W-1:0] irqVector,
    // answers
    output logic irqAck,
    output logic irqDone,
    output logic [irq_prio_pkg::SRC_W-1:0] irqDoneSrc
);
    logic [irq_prio_pkg::SRC_W-1:0] stk[$];
    int cnt;
    // vector is a source number only; table base alignment is software's
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            irqAck <= 1'b0;
            irqDone <= 1'b0;
            irqDoneSrc <= 3'h0;
            cnt = 0;
            stk.delete();
        end else begin
            irqAck <= irqReq && !irqAck;
            if (irqAck && irqReq) begin
                stk.push_back(irqVector);
                cnt = HOLD;
            end else if (stk.size() > 0) begin
                cnt--;
            end
            // preempted handler restarts its run time: simpler, slower
            if (stk.size() > 0 && cnt <= 0) begin
                irqDone <= 1'b1;
                irqDoneSrc <= stk.pop_back();
                cnt = HOLD;
            end else begin
                irqDone <= 1'b0;
                // source lines toggle when no done is flagged
                irqDoneSrc <= ~irqDoneSrc;
            end
        end
    end
endmodule
`default_nettype wire

// file: dv/tb.sv
// self-checking bench of the priority interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic core_clk = 1'b0;
    logic nrst;
    logic ce;
    logic [7:0] regAddr;
    logic [31:0] regWdata;
    logic regWr, regRd, irqReq, irqAck, irqDone, rdSeen = 1'b0;
    logic [31:0] regRdata;
    logic [7:0] irqLine;
    logic [2:0] irqVector, irqDoneSrc;
    logic [7:0] prio[8];
    logic [2:0] expQ[$];
    logic [31:0] rdQ[$];
    int errors = 0;
    int n_tests = 0;
    int b;
    always #10 core_clk = ~core_clk;
    irq_prio_ctrl dut (.core_clk(core_clk), .nrst(nrst), .ce(ce),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .irqLine(irqLine),
        .irqReq(irqReq), .irqVector(irqVector), .irqAck(irqAck),
        .irqDone(irqDone), .irqDoneSrc(irqDoneSrc));
    core_model #(.HOLD(12)) core (.core_clk(core_clk), .nrst(nrst),
        .irqReq(irqReq),
        .irqVector(irqVector), .irqAck(irqAck), .irqDone(irqDone),
        .irqDoneSrc(irqDoneSrc));
    task automatic fail(input string m);
        errors++;
        $display("[ERR] %0t %s", $time, m);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e,
        input string m);
        n_tests++;
        if (g !== e) fail(m);
    endtask
    task stop_test();
        if (errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // pairs of sources share a level so ties are exercised
    function automatic logic [2:0] lv(input int i);
        return 3'(((7 - i) & 6) | b);
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        regRd <= 1'b1;
        regAddr <= a;
        rdQ.push_back(e);
        @(posedge core_clk);
        regRd <= 1'b0;
    endtask
    task automatic exp_set(input logic [7:0] m);
        for (int l = 0; l < 8; l++)
            for (int i = 0; i < 8; i++)
                if (m[i] && lv(i) == l) expQ.push_back(3'(i));
    endtask
    task automatic drain();
        int k;
        k = 0;
        while (expQ.size() > 0 && k < 3000) begin
            @(posedge core_clk);
            k++;
        end
        if (expQ.size() > 0) fail("request not delivered");
        // quiet spell catches any extra delivery
        repeat (30) @(posedge core_clk);
    endtask
    always @(posedge core_clk) begin
        if (rdSeen) chk(regRdata, rdQ.pop_front(), "read data");
        rdSeen = regRd && nrst;
        if (irqAck && irqReq && nrst) begin
            if (expQ.size() == 0) fail("unexpected request taken");
            else chk(32'(irqVector), 32'(expQ.pop_front()), "vector");
        end
    end
    initial begin
        #(20 * 20000);
        fail("watchdog");
        stop_test();
    end
    initial begin
        regAddr = 8'h00;
        regWdata = 32'h0;
        regWr = 1'b0;
        regRd = 1'b0;
        ce = 1'b1;
        irqLine = 8'h00;
        nrst = 1'b0;
        b = $urandom(82625) & 1;
        for (int i = 0; i < 8; i++) prio[i] = {lv(i), 5'($urandom)};
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        rd(irq_prio_pkg::OFS_ENABLE, 32'h0);
        rd(irq_prio_pkg::OFS_MASK, 32'h0);
        rd(irq_prio_pkg::OFS_MASTER, 32'h0);
        rd(8'hFC, 32'h0);
        for (int i = 0; i < 8; i++) rd(8'(32 + 4 * i), 32'h0);
        // a write while the clock enable is low must not land
        ce <= 1'b0;
        wr(irq_prio_pkg::OFS_MASK, 32'h40);
        ce <= 1'b1;
        rd(irq_prio_pkg::OFS_MASK, 32'h0);
        for (int i = 0; i < 8; i++) wr(8'(32 + 4 * i), 32'(prio[i]));
        for (int i = 0; i < 8; i++) rd(8'(32 + 4 * i), 32'(prio[i]));
        wr(irq_prio_pkg::OFS_ENABLE, 32'hFF);
        irqLine <= 8'h08;
        repeat (2) @(posedge core_clk);
        irqLine <= 8'h00;
        repeat (20) @(posedge core_clk);
        rd(irq_prio_pkg::OFS_PENDSET, 32'h08);
        wr(irq_prio_pkg::OFS_MASTER, 32'h1);
        expQ.push_back(3'h3);
        drain();
        rd(irq_prio_pkg::OFS_ENABLE, 32'hFF);
        wr(irq_prio_pkg::OFS_ENABLE, 32'h0);
        wr(irq_prio_pkg::OFS_PENDSET, 32'h0F);
        irqLine <= 8'h10;
        @(posedge core_clk);
        irqLine <= 8'h00;
        repeat (20) @(posedge core_clk);
        wr(irq_prio_pkg::OFS_PENDCLR, 32'h15);
        rd(irq_prio_pkg::OFS_PENDSET, 32'h0A);
        wr(irq_prio_pkg::OFS_ENABLE, 32'hFF);
        exp_set(8'h0A);
        drain();
        wr(irq_prio_pkg::OFS_ENABLE, 32'h0);
        wr(irq_prio_pkg::OFS_MASK, 32'h80);
        wr(irq_prio_pkg::OFS_PENDSET, 32'hFF);
        wr(irq_prio_pkg::OFS_ENABLE, 32'hFF);
        exp_set(8'hF0);
        drain();
        rd(irq_prio_pkg::OFS_PENDSET, 32'h0F);
        wr(irq_prio_pkg::OFS_MASK, 32'h0);
        exp_set(8'h0F);
        drain();
        for (int i = 0; i < 8; i++) begin
            wr(irq_prio_pkg::OFS_TRIGGER, 32'(i));
            expQ.push_back(3'(i));
            drain();
        end
        // a more urgent trigger preempts a running handler
        wr(irq_prio_pkg::OFS_TRIGGER, 32'h0);
        expQ.push_back(3'h0);
        while (expQ.size() > 0) @(posedge core_clk);
        wr(irq_prio_pkg::OFS_TRIGGER, 32'h6);
        expQ.push_back(3'h6);
        drain();
        stop_test();
    end
endmodule
`default_nettype wire
